// ===== core/cmf_consts.svh
// Behaviour
// (RULE_01) Four separate math blocks, each with its own configuration inputs.
// (RULE_02) Each block takes up to five selectable inputs with own limits and scaling.
// (RULE_03) Every input is normalised to percent from its minimum and maximum.
// (RULE_04) Normalised input times signed weight, default 1.0, range -1.0 to 1.0.
// (RULE_05) Each block has four operator stages computing A op B.
// (RULE_06) Each stage result feeds A of the next; last stage is the output.
// (RULE_07) Stage one selects A and B; stages two to four select only B.
// (RULE_08) B source code 0 means unused; stage passes A unchanged.
// (RULE_09) Codes 0 to 5 compare: eq, ne, gt, ge, lt, le, true or false.
// (RULE_10) Code 6 is true when either operand is true.
// (RULE_11) Code 7 is true only when both operands are true.
// (RULE_12) Code 8 is true when exactly one operand is true.
// (RULE_13) Codes 9 to 12: sum, A minus B, product, A divided by B.
// (RULE_14) Code 13 outputs the smaller operand.
// (RULE_15) Code 14 outputs the larger operand.
// (RULE_16) Operand of at least one percent is true; logic results are 0 or 1.
// (RULE_17) Division by zero yields 100 percent.
// (RULE_18) Final percent is mapped to output min..max; limits passed downstream.
// (RULE_19) Normalisation saturates to 0 at or below min, 100 at or above max.
// (RULE_20) Arithmetic results saturate to 0..100 percent, never wrap.
`ifndef CMF_CONSTS_SVH
`define CMF_CONSTS_SVH

`define CMF_NUM_BLOCKS 4
`define CMF_NUM_INPUTS 5
`define CMF_NUM_STAGES 4

// percent in units of 1/256 percent
`define CMF_PCT_FULL 24'sh006400
`define CMF_PCT_ZERO 24'sh000000
`define CMF_PCT_TRUE 24'sh000100

// weight in Q2.14
`define CMF_WGT_ONE 16'sh4000
`define CMF_WGT_NEG_ONE -16'sh4000
`define CMF_WGT_FRAC 14

`define CMF_SRC_UNUSED 3'h0
`define CMF_SRC_LAST 3'h5

`define CMF_OP_EQ 4'h0
`define CMF_OP_NE 4'h1
`define CMF_OP_GT 4'h2
`define CMF_OP_GE 4'h3
`define CMF_OP_LT 4'h4
`define CMF_OP_LE 4'h5
`define CMF_OP_OR 4'h6
`define CMF_OP_AND 4'h7
`define CMF_OP_XOR 4'h8
`define CMF_OP_ADD 4'h9
`define CMF_OP_SUB 4'ha
`define CMF_OP_MUL 4'hb
`define CMF_OP_DIV 4'hc
`define CMF_OP_MIN 4'hd
`define CMF_OP_MAX 4'he

`define CMF_VALID_DEPTH 2

`endif

// ===== core/cmf_pkg.sv
package cmf_pkg;
  typedef logic signed [31:0] cmf_val_t;
  typedef logic signed [23:0] cmf_pct_t;
  typedef logic signed [15:0] cmf_wgt_t;
  typedef logic [3:0] cmf_op_t;
  typedef logic [2:0] cmf_src_t;
endpackage

// ===== core/cmf_stage_if.sv
`timescale 1ns/10ps
interface cmf_stage_if;
  cmf_pkg::cmf_op_t opCode;
  logic bUsed;
  cmf_pkg::cmf_pct_t operandA;
  cmf_pkg::cmf_pct_t operandB;
  cmf_pkg::cmf_pct_t result;
  modport ctl (output opCode, output bUsed, output operandA, output operandB, input result);
  modport alu (input opCode, input bUsed, input operandA, input operandB, output result);
endinterface

// ===== core/cmf_stage_alu.sv
`timescale 1ns/10ps
`include "cmf_consts.svh"
module cmf_stage_alu
(
  // operands, operator and result
  cmf_stage_if.alu port
);
  import cmf_pkg::*;

  logic signed [47:0] wideA;
  logic signed [47:0] wideB;
  logic signed [47:0] wideRes;
  logic aTrue;
  logic bTrue;
  cmf_pct_t res;

  function automatic cmf_pct_t saturate(input logic signed [47:0] v);
    if (v < 48'(`CMF_PCT_ZERO))
    begin
      return `CMF_PCT_ZERO;
    end
    else if (v > 48'(`CMF_PCT_FULL))
    begin
      return `CMF_PCT_FULL;
    end
    return 24'(v);
  endfunction

  function automatic cmf_pct_t asBool(input logic b);
    return b ? `CMF_PCT_TRUE : `CMF_PCT_ZERO; // RULE_16
  endfunction

  always_comb
  begin
    wideA = 48'(port.operandA);
    wideB = 48'(port.operandB);
    aTrue = port.operandA >= `CMF_PCT_TRUE; // RULE_16
    bTrue = port.operandB >= `CMF_PCT_TRUE; // RULE_16
    wideRes = '0;
    res = port.operandA;
    if (port.bUsed) // RULE_08
    begin
      case (port.opCode) // RULE_05
        `CMF_OP_EQ: res = asBool(port.operandA == port.operandB); // RULE_09
        `CMF_OP_NE: res = asBool(port.operandA != port.operandB); // RULE_09
        `CMF_OP_GT: res = asBool(port.operandA > port.operandB); // RULE_09
        `CMF_OP_GE: res = asBool(port.operandA >= port.operandB); // RULE_09
        `CMF_OP_LT: res = asBool(port.operandA < port.operandB); // RULE_09
        `CMF_OP_LE: res = asBool(port.operandA <= port.operandB); // RULE_09
        `CMF_OP_OR: res = asBool(aTrue | bTrue); // RULE_10
        `CMF_OP_AND: res = asBool(aTrue & bTrue); // RULE_11
        `CMF_OP_XOR: res = asBool(aTrue ^ bTrue); // RULE_12
        `CMF_OP_ADD:
        begin
          wideRes = wideA + wideB; // RULE_13
          res = saturate(wideRes); // RULE_20
        end
        `CMF_OP_SUB:
        begin
          wideRes = wideA - wideB; // RULE_13
          res = saturate(wideRes); // RULE_20
        end
        `CMF_OP_MUL:
        begin
          // percent times percent, rescaled back to percent
          wideRes = (wideA * wideB) / 48'(`CMF_PCT_FULL); // RULE_13
          res = saturate(wideRes); // RULE_20
        end
        `CMF_OP_DIV:
        begin
          if (port.operandB == `CMF_PCT_ZERO)
          begin
            res = `CMF_PCT_FULL; // RULE_17
          end
          else
          begin
            wideRes = (wideA * 48'(`CMF_PCT_FULL)) / wideB; // RULE_13
            res = saturate(wideRes); // RULE_20
          end
        end
        `CMF_OP_MIN: res = saturate((wideA < wideB) ? wideA : wideB); // RULE_14
        `CMF_OP_MAX: res = saturate((wideA > wideB) ? wideA : wideB); // RULE_15
        // undefined codes behave as pass-through
        default: res = port.operandA;
      endcase
    end
  end

  assign port.result = res;
endmodule

// ===== core/cmf_math_block.sv
`timescale 1ns/10ps
`include "cmf_consts.svh"
module cmf_math_block
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // input signals from other function blocks
  input wire cmf_pkg::cmf_val_t inValue [`CMF_NUM_BLOCKS][`CMF_NUM_INPUTS],
  // per input limits and weights
  input wire cmf_pkg::cmf_val_t inMin [`CMF_NUM_BLOCKS][`CMF_NUM_INPUTS],
  input wire cmf_pkg::cmf_val_t inMax [`CMF_NUM_BLOCKS][`CMF_NUM_INPUTS],
  input wire cmf_pkg::cmf_wgt_t inWeight [`CMF_NUM_BLOCKS][`CMF_NUM_INPUTS],
  // operand sources and operators
  input wire cmf_pkg::cmf_src_t firstOperandSrc [`CMF_NUM_BLOCKS],
  input wire cmf_pkg::cmf_src_t secondOperandSrc [`CMF_NUM_BLOCKS][`CMF_NUM_STAGES],
  input wire cmf_pkg::cmf_op_t stageOp [`CMF_NUM_BLOCKS][`CMF_NUM_STAGES],
  // output range
  input wire cmf_pkg::cmf_val_t outMin [`CMF_NUM_BLOCKS],
  input wire cmf_pkg::cmf_val_t outMax [`CMF_NUM_BLOCKS],
  // results
  output cmf_pkg::cmf_pct_t mathPct [`CMF_NUM_BLOCKS],
  output cmf_pkg::cmf_val_t mathOut [`CMF_NUM_BLOCKS],
  output cmf_pkg::cmf_val_t mathLimitMin [`CMF_NUM_BLOCKS],
  output cmf_pkg::cmf_val_t mathLimitMax [`CMF_NUM_BLOCKS],
  output logic mathValid
);
  import cmf_pkg::*;

  cmf_pct_t normReg [`CMF_NUM_BLOCKS][`CMF_NUM_INPUTS];
  cmf_pct_t pctReg [`CMF_NUM_BLOCKS];
  cmf_val_t outReg [`CMF_NUM_BLOCKS];
  cmf_val_t limMinReg [`CMF_NUM_BLOCKS];
  cmf_val_t limMaxReg [`CMF_NUM_BLOCKS];
  logic [`CMF_VALID_DEPTH:0] validReg;

  function automatic cmf_pct_t normalise(input cmf_val_t x, input cmf_val_t lo, input cmf_val_t hi);
    logic signed [63:0] num;
    logic signed [63:0] den;
    num = (64'(x) - 64'(lo)) * 64'(`CMF_PCT_FULL);
    den = 64'(hi) - 64'(lo);
    if (x <= lo)
    begin
      return `CMF_PCT_ZERO; // RULE_19
    end
    else if (x >= hi)
    begin
      return `CMF_PCT_FULL; // RULE_19
    end
    return 24'(num / den); // RULE_03
  endfunction

  function automatic cmf_pct_t applyWeight(input cmf_pct_t p, input cmf_wgt_t w);
    cmf_wgt_t wc;
    logic signed [39:0] prod;
    // out-of-range weights are clamped rather than rejected
    wc = w;
    if (w > `CMF_WGT_ONE)
    begin
      wc = `CMF_WGT_ONE;
    end
    else if (w < `CMF_WGT_NEG_ONE)
    begin
      wc = `CMF_WGT_NEG_ONE;
    end
    prod = 40'(p) * 40'(wc); // RULE_04
    return 24'(prod >>> `CMF_WGT_FRAC);
  endfunction

  function automatic cmf_pct_t pickInput(input cmf_src_t src, input cmf_pct_t v [`CMF_NUM_INPUTS]);
    cmf_src_t idx;
    // codes 6 and 7 name no input, so they read as zero like code 0
    idx = src - 3'h1;
    if (src == `CMF_SRC_UNUSED || src > `CMF_SRC_LAST)
    begin
      return `CMF_PCT_ZERO;
    end
    return v[idx]; // RULE_02
  endfunction

  genvar blk;
  genvar inp;
  genvar stg;

  generate
    for (blk = 0; blk < `CMF_NUM_BLOCKS; blk++) // RULE_01
    begin : g_blk
      cmf_pct_t stageRes [`CMF_NUM_STAGES];
      logic signed [63:0] physWide;

      // input conditioning, one register per input
      for (inp = 0; inp < `CMF_NUM_INPUTS; inp++) // RULE_02
      begin : g_inp
        always_ff @(posedge ref_clk)
        begin
          if (!nrst)
          begin
            normReg[blk][inp] <= `CMF_PCT_ZERO;
          end
          else
          begin
            normReg[blk][inp] <= applyWeight(normalise(inValue[blk][inp], inMin[blk][inp], inMax[blk][inp]),
                                             inWeight[blk][inp]); // RULE_03 RULE_04
          end
        end
      end

      // operator chain is combinational so A and B come from one input sample
      for (stg = 0; stg < `CMF_NUM_STAGES; stg++) // RULE_05
      begin : g_stg
        cmf_stage_if link ();

        always_comb
        begin
          link.opCode = stageOp[blk][stg];
          link.bUsed = secondOperandSrc[blk][stg] != `CMF_SRC_UNUSED; // RULE_08
          link.operandB = pickInput(secondOperandSrc[blk][stg], normReg[blk]); // RULE_07
        end

        // picked at elaboration so no stage can read its own result
        if (stg == 0)
        begin : g_first
          assign link.operandA = pickInput(firstOperandSrc[blk], normReg[blk]); // RULE_07
        end
        else
        begin : g_next
          assign link.operandA = stageRes[stg - 1]; // RULE_06
        end

        cmf_stage_alu u_alu
        (
          .port(link.alu)
        );

        assign stageRes[stg] = link.result;
      end

      always_ff @(posedge ref_clk)
      begin
        if (!nrst)
        begin
          pctReg[blk] <= `CMF_PCT_ZERO;
        end
        else
        begin
          pctReg[blk] <= stageRes[`CMF_NUM_STAGES - 1]; // RULE_06
        end
      end

      // mapping keeps the percent and the range register in step
      assign physWide = 64'(outMin[blk])
                        + (64'(pctReg[blk]) * (64'(outMax[blk]) - 64'(outMin[blk])))
                        / 64'(`CMF_PCT_FULL);

      always_ff @(posedge ref_clk)
      begin
        if (!nrst)
        begin
          outReg[blk] <= '0;
        end
        else
        begin
          outReg[blk] <= 32'(physWide); // RULE_18
        end
      end

      // range copies for consumers, sampled on the same edge as the value
      always_ff @(posedge ref_clk)
      begin
        if (!nrst)
        begin
          limMinReg[blk] <= '0;
          limMaxReg[blk] <= '0;
        end
        else
        begin
          limMinReg[blk] <= outMin[blk]; // RULE_18
          limMaxReg[blk] <= outMax[blk]; // RULE_18
        end
      end

      assign mathOut[blk] = outReg[blk];
      assign mathLimitMin[blk] = limMinReg[blk];
      assign mathLimitMax[blk] = limMaxReg[blk];
    end
  endgenerate

  // percent output delayed one cycle to line up with the physical value
  cmf_pct_t pctOutReg [`CMF_NUM_BLOCKS];

  generate
    for (blk = 0; blk < `CMF_NUM_BLOCKS; blk++)
    begin : g_pct
      always_ff @(posedge ref_clk)
      begin
        if (!nrst)
        begin
          pctOutReg[blk] <= `CMF_PCT_ZERO;
        end
        else
        begin
          pctOutReg[blk] <= pctReg[blk];
        end
      end

      assign mathPct[blk] = pctOutReg[blk];
    end
  endgenerate

  // valid marks a full pipeline after reset
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      validReg <= '0;
    end
    else
    begin
      validReg <= {validReg[`CMF_VALID_DEPTH - 1:0], 1'b1};
    end
  end

  assign mathValid = validReg[`CMF_VALID_DEPTH];
endmodule

// ===== tb/cmf_math_sva.sv
`timescale 1ns/10ps
`include "cmf_consts.svh"
module cmf_math_sva
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // configuration
  input wire cmf_pkg::cmf_src_t firstOperandSrc [`CMF_NUM_BLOCKS],
  input wire cmf_pkg::cmf_src_t secondOperandSrc [`CMF_NUM_BLOCKS][`CMF_NUM_STAGES],
  input wire cmf_pkg::cmf_op_t stageOp [`CMF_NUM_BLOCKS][`CMF_NUM_STAGES],
  input wire cmf_pkg::cmf_val_t outMin [`CMF_NUM_BLOCKS],
  input wire cmf_pkg::cmf_val_t outMax [`CMF_NUM_BLOCKS],
  // results
  input wire cmf_pkg::cmf_pct_t mathPct [`CMF_NUM_BLOCKS],
  input wire cmf_pkg::cmf_val_t mathOut [`CMF_NUM_BLOCKS],
  input wire cmf_pkg::cmf_val_t mathLimitMin [`CMF_NUM_BLOCKS],
  input wire cmf_pkg::cmf_val_t mathLimitMax [`CMF_NUM_BLOCKS],
  input wire logic mathValid
);
  import cmf_pkg::*;
  // edges since reset release, saturating so it never wraps back
  logic [1:0] relCnt_reg;
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      relCnt_reg <= 2'h0;
    else if (relCnt_reg != 2'h3)
      relCnt_reg <= relCnt_reg + 2'h1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // release, three edges still empty, then the pipeline is full
  sequence fill_s;
    !mathValid [*3] ##1 mathValid;
  endsequence
  valid_fill_a: assert property ($rose(nrst) |-> fill_s)
    else $error("valid not raised on pipeline fill");
  reset_clear_a: assert property (!$past(nrst) |-> !mathValid && mathPct[0] == 0 && mathOut[0] == 0)
    else $error("outputs not cleared by reset");
  valid_early_a: assert property (relCnt_reg != 2'h3 |-> !mathValid)
    else $error("valid raised too early");
  valid_late_a: assert property (relCnt_reg == 2'h3 |-> mathValid)
    else $error("valid missing after pipeline fill");
  valid_hold_a: assert property (mathValid |=> mathValid)
    else $error("valid dropped outside reset");
  for (genvar b = 0; b < `CMF_NUM_BLOCKS; b++)
  begin : g_blk
    limit_copy_a: assert property ($past(nrst) |-> mathLimitMin[b] == $past(outMin[b]) &&
      mathLimitMax[b] == $past(outMax[b])) else $error("limit outputs differ from range");
    out_map_a: assert property (mathValid |-> longint'(mathOut[b]) == longint'($past(outMin[b])) +
      longint'(mathPct[b]) * (longint'($past(outMax[b])) - longint'($past(outMin[b]))) / 64'sd25600)
      else $error("physical output mapping wrong");
    logic_pct_a: assert property ($past(stageOp[b][3], 2) <= 4'h8 &&
      $past(secondOperandSrc[b][3], 2) inside {[3'h1:3'h5]} |-> mathPct[b] == 0 || mathPct[b] == 256)
      else $error("logic result not 0 or 1");
    pass_zero_a: assert property ($past(firstOperandSrc[b], 2) == 0 && $past(secondOperandSrc[b][0], 2) == 0 &&
      $past(secondOperandSrc[b][1], 2) == 0 && $past(secondOperandSrc[b][2], 2) == 0 &&
      $past(secondOperandSrc[b][3], 2) == 0 |-> mathPct[b] == 0) else $error("unused operand not passed");
  end
endmodule

bind cmf_math_block cmf_math_sva chk_u (.ref_clk(ref_clk), .nrst(nrst), .firstOperandSrc(firstOperandSrc),
  .secondOperandSrc(secondOperandSrc), .stageOp(stageOp), .outMin(outMin), .outMax(outMax), .mathPct(mathPct),
  .mathOut(mathOut), .mathLimitMin(mathLimitMin), .mathLimitMax(mathLimitMax), .mathValid(mathValid));

// ===== tb/cmf_src_model.sv
`timescale 1ns/10ps
`include "cmf_consts.svh"
module cmf_src_model
(
  // clock
  input wire logic ref_clk,
  // levels the upstream blocks settle to
  input wire cmf_pkg::cmf_val_t srcLevel [`CMF_NUM_BLOCKS][`CMF_NUM_INPUTS],
  // signals into the math blocks
  output cmf_pkg::cmf_val_t inValue [`CMF_NUM_BLOCKS][`CMF_NUM_INPUTS]
);
  import cmf_pkg::*;
  initial inValue = '{default: 32'sh0};
  // upstream outputs move on the falling edge, clear of the sampling edge
  always @(negedge ref_clk)
    inValue <= srcLevel;
endmodule

// ===== tb/testbench.sv
`timescale 1ns/10ps
`include "cmf_consts.svh"
module testbench;
  import cmf_pkg::*;
  localparam int NB = `CMF_NUM_BLOCKS;
  localparam int NI = `CMF_NUM_INPUTS;
  localparam int NS = `CMF_NUM_STAGES;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  cmf_val_t srcLevel [NB][NI], inValue [NB][NI], inMin [NB][NI], inMax [NB][NI];
  cmf_wgt_t inWeight [NB][NI];
  cmf_src_t firstOperandSrc [NB], secondOperandSrc [NB][NS];
  cmf_op_t stageOp [NB][NS];
  cmf_val_t outMin [NB], outMax [NB], mathOut [NB], mathLimitMin [NB], mathLimitMax [NB];
  cmf_pct_t mathPct [NB];
  logic mathValid;
  int n_errors = 0;
  int comparisons = 0;
  int pa [7] = '{500, 750, 250, 400, 1000, -5, 10};
  int pb [7] = '{500, 250, 750, 0, 1000, 2000, 9};
  cmf_op_t chainOps [4][4] = '{'{4'h9, 4'he, 4'ha, 4'hc}, '{4'hb, 4'hd, 4'h6, 4'h9},
    '{4'ha, 4'h9, 4'hc, 4'h8}, '{4'hc, 4'hb, 4'h7, 4'ha}};
  always #5 ref_clk = ~ref_clk;
  cmf_src_model src_u (.ref_clk(ref_clk), .srcLevel(srcLevel), .inValue(inValue));
  cmf_math_block dut_u (.ref_clk(ref_clk), .nrst(nrst), .inValue(inValue), .inMin(inMin), .inMax(inMax),
    .inWeight(inWeight), .firstOperandSrc(firstOperandSrc), .secondOperandSrc(secondOperandSrc),
    .stageOp(stageOp), .outMin(outMin), .outMax(outMax), .mathPct(mathPct), .mathOut(mathOut),
    .mathLimitMin(mathLimitMin), .mathLimitMax(mathLimitMax), .mathValid(mathValid));
  function automatic longint tf(bit c);
    return c ? 256 : 0;
  endfunction
  function automatic longint sat(longint v);
    return v < 0 ? 0 : v > 25600 ? 25600 : v;
  endfunction
  function automatic longint nw(int b, int i);
    longint x, mn, mx, n, w;
    x = srcLevel[b][i];
    mn = inMin[b][i];
    mx = inMax[b][i];
    w = inWeight[b][i];
    n = x <= mn ? 0 : x >= mx ? 25600 : (x - mn) * 25600 / (mx - mn);
    w = w > 16384 ? 16384 : w < -16384 ? -16384 : w;
    return (n * w) >>> 14;
  endfunction
  function automatic longint ref_pct(int b);
    longint a, v;
    int s1;
    s1 = firstOperandSrc[b];
    a = (s1 >= 1 && s1 <= 5) ? nw(b, s1 - 1) : 0;
    for (int s = 0; s < NS; s++)
    begin
      s1 = secondOperandSrc[b][s];
      if (s1 == 0)
        continue;
      v = s1 <= 5 ? nw(b, s1 - 1) : 0;
      case (stageOp[b][s])
        4'h0: a = tf(a == v);
        4'h1: a = tf(a != v);
        4'h2: a = tf(a > v);
        4'h3: a = tf(a >= v);
        4'h4: a = tf(a < v);
        4'h5: a = tf(a <= v);
        4'h6: a = tf(a >= 256 || v >= 256);
        4'h7: a = tf(a >= 256 && v >= 256);
        4'h8: a = tf((a >= 256) != (v >= 256));
        4'h9: a = sat(a + v);
        4'ha: a = sat(a - v);
        4'hb: a = sat(a * v / 25600);
        4'hc: a = v == 0 ? 25600 : sat(a * 25600 / v);
        4'hd: a = sat(a < v ? a : v);
        4'he: a = sat(a > v ? a : v);
        default: ;
      endcase
    end
    return a;
  endfunction
  task automatic cmp(input cmf_val_t got, input cmf_val_t exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp, input string what);
    cmp(32'(got), 32'(exp), what);
  endtask
  task automatic settle_check();
    longint p;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    for (int b = 0; b < NB; b++)
    begin
      p = ref_pct(b);
      cmp(mathPct[b], p, "percent");
      cmp(mathOut[b], outMin[b] + p * (outMax[b] - outMin[b]) / 25600, "output");
      cmp(mathLimitMax[b], outMax[b], "limit");
      cmp(mathLimitMin[b], outMin[b], "limit");
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_errors++;
    stop_test();
  end
  initial
  begin
    srcLevel = '{default: 32'sh0};
    inMin = '{default: 32'sh0};
    inMax = '{default: 32'sh3e8};
    inWeight = '{default: 16'sh4000};
    firstOperandSrc = '{default: 3'h0};
    secondOperandSrc = '{default: 3'h0};
    stageOp = '{default: 4'h0};
    for (int b = 0; b < NB; b++)
    begin
      outMin[b] = -100 * b;
      outMax[b] = 1000 + 3000 * b;
    end
    repeat (6) @(negedge ref_clk);
    cmp_flag(mathValid, 1'b0, "valid in reset");
    nrst <= 1'b1;
    settle_check();
    cmp_flag(mathValid, 1'b1, "valid");
    // each block gets another operator so crosstalk between blocks shows
    for (int p = 0; p < 7; p++)
      for (int op = 0; op < 16; op++)
      begin
        for (int b = 0; b < NB; b++)
        begin
          srcLevel[b][0] <= pa[p];
          srcLevel[b][1] <= pb[p];
          firstOperandSrc[b] <= 3'h1;
          secondOperandSrc[b][0] <= 3'h2;
          stageOp[b][0] <= 4'((op + b) % 16);
        end
        settle_check();
      end
    // unused and out-of-range source codes read as zero
    for (int b = 0; b < NB; b++)
    begin
      firstOperandSrc[b] <= 3'(6 * (b % 2));
      secondOperandSrc[b][0] <= 3'(7 * (b % 2));
    end
    settle_check();
    nrst <= 1'b0;
    repeat (2) @(negedge ref_clk);
    cmp(mathPct[1], 0, "percent in reset");
    cmp_flag(mathValid, 1'b0, "valid in mid reset");
    nrst <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      for (int b = 0; b < NB; b++)
      begin
        srcLevel[b][2] <= 300 + 100 * b;
        srcLevel[b][3] <= 50 + 550 * k;
        srcLevel[b][4] <= 1200;
        inMin[b][3] <= 100;
        inWeight[b][2] <= 16'sh2000;
        inWeight[b][3] <= -16'sh4000;
        inWeight[b][4] <= 16'sh7fff;
        firstOperandSrc[b] <= 3'(b + 2);
        outMin[b] <= -3000 * k;
        for (int s = 0; s < NS; s++)
        begin
          secondOperandSrc[b][s] <= 3'(s + 2);
          stageOp[b][s] <= chainOps[b][s];
        end
      end
      settle_check();
    end
    stop_test();
  end
endmodule
